// ==== hw/mepic_pkg.sv ====
package mepic_pkg;

	// special function register addresses
	localparam logic [7:0] SFR_TCON      = 8'h88;
	localparam logic [7:0] SFR_IEN2      = 8'h9a;
	localparam logic [7:0] SFR_IEN0      = 8'ha8;
	localparam logic [7:0] SFR_PRIO_LOW  = 8'ha9;
	localparam logic [7:0] SFR_IEN1      = 8'hb8;
	localparam logic [7:0] SFR_PRIO_HIGH = 8'hb9;
	localparam logic [7:0] SFR_IRCON     = 8'hc0;
	localparam logic [7:0] SFR_TIMER2_CONTROL_REG     = 8'hc8;
	localparam logic [7:0] SFR_SUB_FLAGS = 8'he8;

	// memory-mapped enable and flag bytes
	localparam logic [15:0] XR_EN_WAKE = 16'h2002;
	localparam logic [15:0] XR_EN_LOCK = 16'h2007;
	localparam logic [15:0] XR_EN_MISC = 16'h20b0;
	localparam logic [15:0] XR_FL_MISC = 16'h20b1;

	// writable bit masks; other bits read zero
	localparam logic [7:0] MASK_IEN0  = 8'h9f;
	localparam logic [7:0] MASK_IEN1  = 8'h3e;
	localparam logic [7:0] MASK_IEN2  = 8'h01;
	localparam logic [7:0] MASK_TCON  = 8'h0a;
	localparam logic [7:0] MASK_IRCON = 8'h3e;
	localparam logic [7:0] MASK_TIMER2_CONTROL_REG = 8'h60;
	localparam logic [7:0] MASK_PRIO  = 8'h3f;
	localparam logic [7:0] MASK_XWAKE = 8'h03;
	localparam logic [7:0] MASK_XLOCK = 8'h30;
	localparam logic [7:0] MASK_XMISC = 8'h11;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// field positions
	localparam int IEN0_EX0  = 0;
	localparam int IEN0_ET0  = 1;
	localparam int IEN0_EX1  = 2;
	localparam int IEN0_ET1  = 3;
	localparam int IEN0_ES0  = 4;
	localparam int IEN0_GLOB = 7;
	localparam int IEN2_ES1  = 0;
	localparam int TCON_F0   = 1;
	localparam int TCON_F1   = 3;
	localparam int T2_POL2   = 5;
	localparam int T2_POL3   = 6;
	localparam int SF_XFER   = 0;
	localparam int SF_RTC    = 1;
	localparam int SF_COL1   = 2;
	localparam int SF_COL0   = 3;
	localparam int SF_BUTTON = 4;
	localparam int SF_TWAKE  = 5;
	localparam int SF_LRISE  = 6;
	localparam int SF_LFALL  = 7;
	localparam int XW_XFER   = 0;
	localparam int XW_RTC    = 1;
	localparam int XL_COL    = 4;
	localparam int XL_LOCK   = 5;
	localparam int XM_WDOG   = 0;
	localparam int XM_SPI    = 4;

	// sources in polling order
	localparam int NUM_SRC = 11;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_SER1 = 4'h1;
	localparam logic [3:0] SRC_TIM0 = 4'h2;
	localparam logic [3:0] SRC_EXT2 = 4'h3;
	localparam logic [3:0] SRC_EXT1 = 4'h4;
	localparam logic [3:0] SRC_EXT3 = 4'h5;
	localparam logic [3:0] SRC_TIM1 = 4'h6;
	localparam logic [3:0] SRC_EXT4 = 4'h7;
	localparam logic [3:0] SRC_SER0 = 4'h8;
	localparam logic [3:0] SRC_EXT5 = 4'h9;
	localparam logic [3:0] SRC_EXT6 = 4'ha;
	// two polling slots per group, external 6 alone in group 5
	localparam int SLOTS_PER_GROUP = 2;

	typedef struct packed {
		logic       valid;
		logic [3:0] src;
		logic [1:0] level;
	} mepic_req_t;

endpackage

// ==== hw/mepic_edge.sv ====
`timescale 1ns/1ps
module mepic_edge
	import mepic_pkg::*;
#(
	parameter int WIDTH = 1
)(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] sig,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;

	always_comb
	begin
		prev_d = sig;
		rise   = sig & ~prev_q;
		fall   = ~sig & prev_q;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prev_q <= '0;
		else
			prev_q <= prev_d;
	end

endmodule // mepic_edge

// ==== hw/mepic_ctrl.sv ====
// Operation
// - seven external lines from on-chip peripheral sources
// - lines 2 and 3 polarity software selectable
// - lines 5 and 6 fire on source falling
// - line 4 both lock edges; line 3 busy falling
// - line 6 manual clear; lines 0-5 auto clear
// - lines 0 and 1 from digital I/O paths
// - line 2 merges two collisions and serial
// - line sub-sources have flag and enable (pairs share one); gate parent
// - core flags 0-5 cleared when core vectors
// - sub and wake flags clear on zero only
// - wake flags set on wakeup, no interrupt
// - button flag set on every press
// - six priority groups of paired sources, external 6 alone
// - level from high and low priority bits
// - fixed polling order among equal levels
// - line 2-6 enables and flags bits 1-5
// - sub-source flag byte bit layout
// - watchdog and serial enable, flag bytes
// - preempt only by strictly higher level
// - polarity 0 falling, 1 rising
// - global enable zero blocks all sources
`timescale 1ns/1ps
module mepic_ctrl
	import mepic_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWrEn,
	input  wire logic [7:0]  sfrWrData,
	output logic      [7:0]  sfrRdData,
	input  wire logic [15:0] xAddr,
	input  wire logic        xWrEn,
	input  wire logic [7:0]  xWrData,
	output logic      [7:0]  xRdData,
	input  wire logic        dioHighEvent,
	input  wire logic        dioLowEvent,
	input  wire logic        flashCollisionA,
	input  wire logic        flashCollisionB,
	input  wire logic        spiEvent,
	input  wire logic        ceBusy,
	input  wire logic        pllLock,
	input  wire logic        eepromBusy,
	input  wire logic        transferBusy,
	input  wire logic        oneSecondTick,
	input  wire logic        watchdogNearOverflow,
	input  wire logic        timerWakeup,
	input  wire logic        pushButton,
	input  wire logic        timer0Req,
	input  wire logic        timer1Req,
	input  wire logic        serial0Req,
	input  wire logic        serial1Req,
	input  wire logic        ackValid,
	input  wire logic [3:0]  ackSrc,
	input  wire logic        retiPulse,
	output mepic_req_t       irqReq
);

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]  ien0_q, ien0_d, ien1_q, ien1_d, ien2_q, ien2_d, timer2_control_reg_q, timer2_control_reg_d;
	logic [7:0]  prioLow_q, prioLow_d, prioHigh_q, prioHigh_d;
	logic [7:0]  enWake_q, enWake_d, enLock_q, enLock_d, enMisc_q, enMisc_d;
	logic [7:0]  subFlag_q, subFlag_d, miscFlag_q, miscFlag_d;
	logic [6:0]  coreFlag_q, coreFlag_d;
	logic [3:0]  inService_q, inService_d;
	logic [7:0]  sfrRd_q, sfrRd_d, xRd_q, xRd_d;
	mepic_req_t  irq_q, irq_d;
	logic [10:0] rawRise, rawFall;
	logic [4:0]  lineRise, lineFall, lineLvl;
	logic [7:0]  subSet, miscSet;
	logic [6:0]  coreSet;
	logic [NUM_SRC-1:0] pending;
	logic        sfrHit, any2, any4, any6, haveActive, ackIsExt;
	logic [1:0]  curLevel, ackLevel;
	logic [2:0]  ackExt;

	assign sfrRdData = sfrRd_q;
	assign xRdData   = xRd_q;
	assign irqReq    = irq_q;

	function automatic logic [1:0] levelOf(input logic [3:0] src, input logic [7:0] lo,
		input logic [7:0] hi);
		int g;
		g = int'(src) / SLOTS_PER_GROUP;
		return {hi[g], lo[g]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// edge detection of raw sources and of the merged lines
	mepic_edge #(.WIDTH(11)) u_rawEdge (
		.clk  (clk),
		.rstn (rstn),
		.sig  ({pushButton, timerWakeup, watchdogNearOverflow, oneSecondTick,
		        transferBusy, pllLock, spiEvent, flashCollisionB, flashCollisionA,
		        dioLowEvent, dioHighEvent}),
		.rise (rawRise),
		.fall (rawFall)
	);

	always_comb
	begin
		// each sub flag reaches its line only through an enable; the two collision flags share one, as do the two lock flags
		any2 = (subFlag_q[SF_COL0] | subFlag_q[SF_COL1]) & enLock_q[XL_COL]
		     | miscFlag_q[XM_SPI] & enMisc_q[XM_SPI];
		any4 = (subFlag_q[SF_LRISE] | subFlag_q[SF_LFALL]) & enLock_q[XL_LOCK];
		any6 = subFlag_q[SF_XFER] & enWake_q[XW_XFER]
		     | subFlag_q[SF_RTC] & enWake_q[XW_RTC]
		     | miscFlag_q[XM_WDOG] & enMisc_q[XM_WDOG];
		// active-low request on line 2 so a new request is a falling edge
		lineLvl = {any6, ~eepromBusy, any4, ceBusy, ~any2};
	end

	mepic_edge #(.WIDTH(5)) u_lineEdge (
		.clk  (clk),
		.rstn (rstn),
		.sig  (lineLvl),
		.rise (lineRise),
		.fall (lineFall)
	);

	////////////////////////////////////////////////////////////////////////////
	// flags
	always_comb
	begin
		sfrHit = sfrWrEn;
		subSet = '0;
		subSet[SF_XFER]   = rawFall[6];
		subSet[SF_RTC]    = rawFall[7];
		subSet[SF_COL1]   = rawRise[3];
		subSet[SF_COL0]   = rawRise[2];
		subSet[SF_BUTTON] = rawRise[10];
		subSet[SF_TWAKE]  = rawRise[9];
		subSet[SF_LRISE]  = rawRise[5];
		subSet[SF_LFALL]  = rawFall[5];
		miscSet = '0;
		miscSet[XM_WDOG] = rawFall[8];
		miscSet[XM_SPI]  = rawRise[4];
		coreSet[0] = rawRise[0];
		coreSet[1] = rawRise[1];
		coreSet[2] = timer2_control_reg_q[T2_POL2] ? lineRise[0] : lineFall[0];
		coreSet[3] = timer2_control_reg_q[T2_POL3] ? lineRise[1] : lineFall[1];
		coreSet[4] = lineRise[2];
		coreSet[5] = lineRise[3];
		coreSet[6] = lineRise[4];

		ackIsExt = 1'b1;
		ackExt   = 3'h0;
		case (ackSrc)
			SRC_EXT0: ackExt = 3'h0;
			SRC_EXT1: ackExt = 3'h1;
			SRC_EXT2: ackExt = 3'h2;
			SRC_EXT3: ackExt = 3'h3;
			SRC_EXT4: ackExt = 3'h4;
			SRC_EXT5: ackExt = 3'h5;
			default:  ackIsExt = 1'b0;
		endcase

		subFlag_d  = subFlag_q;
		miscFlag_d = miscFlag_q;
		coreFlag_d = coreFlag_q;
		if (sfrHit && sfrAddr == SFR_SUB_FLAGS)
			subFlag_d = subFlag_q & sfrWrData;
		if (xWrEn && xAddr == XR_FL_MISC)
			miscFlag_d = miscFlag_q & (xWrData | ~MASK_XMISC);
		if (sfrHit && sfrAddr == SFR_TCON)
		begin
			coreFlag_d[0] = sfrWrData[TCON_F0];
			coreFlag_d[1] = sfrWrData[TCON_F1];
		end
		if (sfrHit && sfrAddr == SFR_IRCON)
			coreFlag_d[6:2] = sfrWrData[5:1];
		// external 6 is left for its handler to clear
		if (ackValid && ackIsExt)
			coreFlag_d[ackExt] = 1'b0;
		// set beats any clear landing in the same cycle
		subFlag_d  = subFlag_d | subSet;
		miscFlag_d = miscFlag_d | miscSet;
		coreFlag_d = coreFlag_d | coreSet;
	end

	////////////////////////////////////////////////////////////////////////////
	// register writes and read mux
	always_comb
	begin
		ien0_d = ien0_q;
		ien1_d = ien1_q;
		ien2_d = ien2_q;
		timer2_control_reg_d = timer2_control_reg_q;
		prioLow_d = prioLow_q;
		prioHigh_d = prioHigh_q;
		enWake_d = enWake_q;
		enLock_d = enLock_q;
		enMisc_d = enMisc_q;
		// priority changes take effect at once; software must avoid doing so live
		if (sfrHit)
		begin
			case (sfrAddr)
				SFR_IEN0:      ien0_d = sfrWrData & MASK_IEN0;
				SFR_IEN1:      ien1_d = sfrWrData & MASK_IEN1;
				SFR_IEN2:      ien2_d = sfrWrData & MASK_IEN2;
				SFR_TIMER2_CONTROL_REG:     timer2_control_reg_d = sfrWrData & MASK_TIMER2_CONTROL_REG;
				SFR_PRIO_LOW:  prioLow_d = sfrWrData & MASK_PRIO;
				SFR_PRIO_HIGH: prioHigh_d = sfrWrData & MASK_PRIO;
				default:       ien0_d = ien0_q;
			endcase
		end
		if (xWrEn)
		begin
			case (xAddr)
				XR_EN_WAKE: enWake_d = xWrData & MASK_XWAKE;
				XR_EN_LOCK: enLock_d = xWrData & MASK_XLOCK;
				XR_EN_MISC: enMisc_d = xWrData & MASK_XMISC;
				default:    enWake_d = enWake_q;
			endcase
		end
		case (sfrAddr)
			SFR_IEN0:      sfrRd_d = ien0_q;
			SFR_IEN1:      sfrRd_d = ien1_q;
			SFR_IEN2:      sfrRd_d = ien2_q;
			SFR_TIMER2_CONTROL_REG:     sfrRd_d = timer2_control_reg_q;
			SFR_PRIO_LOW:  sfrRd_d = prioLow_q;
			SFR_PRIO_HIGH: sfrRd_d = prioHigh_q;
			SFR_TCON:      sfrRd_d = {4'h0, coreFlag_q[1], 1'b0, coreFlag_q[0], 1'b0};
			SFR_IRCON:     sfrRd_d = {2'h0, coreFlag_q[6:2], 1'b0};
			SFR_SUB_FLAGS: sfrRd_d = subFlag_q;
			default:       sfrRd_d = RESET_BYTE;
		endcase
		case (xAddr)
			XR_EN_WAKE: xRd_d = enWake_q;
			XR_EN_LOCK: xRd_d = enLock_q;
			XR_EN_MISC: xRd_d = enMisc_q;
			XR_FL_MISC: xRd_d = miscFlag_q;
			default:    xRd_d = RESET_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration and in-service levels
	always_comb
	begin
		logic [1:0] bestLvl;
		logic [1:0] lvl;
		logic       found;
		bestLvl = 2'h0;
		lvl     = 2'h0;
		found   = 1'b0;
		pending[SRC_EXT0] = coreFlag_q[0] & ien0_q[IEN0_EX0];
		pending[SRC_SER1] = serial1Req & ien2_q[IEN2_ES1];
		pending[SRC_TIM0] = timer0Req & ien0_q[IEN0_ET0];
		pending[SRC_EXT2] = coreFlag_q[2] & ien1_q[1];
		pending[SRC_EXT1] = coreFlag_q[1] & ien0_q[IEN0_EX1];
		pending[SRC_EXT3] = coreFlag_q[3] & ien1_q[2];
		pending[SRC_TIM1] = timer1Req & ien0_q[IEN0_ET1];
		pending[SRC_EXT4] = coreFlag_q[4] & ien1_q[3];
		pending[SRC_SER0] = serial0Req & ien0_q[IEN0_ES0];
		pending[SRC_EXT5] = coreFlag_q[5] & ien1_q[4];
		pending[SRC_EXT6] = coreFlag_q[6] & ien1_q[5];
		if (!ien0_q[IEN0_GLOB])
			pending = '0;

		haveActive = |inService_q;
		curLevel   = inService_q[3] ? 2'h3 : inService_q[2] ? 2'h2 :
		             inService_q[1] ? 2'h1 : 2'h0;
		irq_d = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			lvl = levelOf(4'(i), prioLow_q, prioHigh_q);
			// strict compare keeps the earlier poll slot on a tie
			if (pending[i] && (!found || lvl > bestLvl))
			begin
				found     = 1'b1;
				bestLvl   = lvl;
				irq_d.src = 4'(i);
			end
		end
		irq_d.level = bestLvl;
		irq_d.valid = found && (!haveActive || bestLvl > curLevel);

		ackLevel    = levelOf(ackSrc, prioLow_q, prioHigh_q);
		inService_d = inService_q;
		if (retiPulse)
			inService_d[curLevel] = 1'b0;
		if (ackValid)
			inService_d[ackLevel] = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ien0_q <= RESET_BYTE;
			ien1_q <= RESET_BYTE;
			ien2_q <= RESET_BYTE;
			timer2_control_reg_q <= RESET_BYTE;
			prioLow_q <= RESET_BYTE;
			prioHigh_q <= RESET_BYTE;
			enWake_q <= RESET_BYTE;
			enLock_q <= RESET_BYTE;
			enMisc_q <= RESET_BYTE;
			subFlag_q <= RESET_BYTE;
			miscFlag_q <= RESET_BYTE;
			coreFlag_q <= '0;
			inService_q <= '0;
			sfrRd_q <= RESET_BYTE;
			xRd_q <= RESET_BYTE;
			irq_q <= '0;
		end
		else
		begin
			ien0_q <= ien0_d;
			ien1_q <= ien1_d;
			ien2_q <= ien2_d;
			timer2_control_reg_q <= timer2_control_reg_d;
			prioLow_q <= prioLow_d;
			prioHigh_q <= prioHigh_d;
			enWake_q <= enWake_d;
			enLock_q <= enLock_d;
			enMisc_q <= enMisc_d;
			subFlag_q <= subFlag_d;
			miscFlag_q <= miscFlag_d;
			coreFlag_q <= coreFlag_d;
			inService_q <= inService_d;
			sfrRd_q <= sfrRd_d;
			xRd_q <= xRd_d;
			irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_EXT5_FALL: assert property (@(posedge clk) disable iff (!rstn)
		$fell(eepromBusy) |=> coreFlag_q[5])
		else $error("eeprom busy fall did not flag line 5");
	AST_EXT3_POL: assert property (@(posedge clk) disable iff (!rstn)
		!timer2_control_reg_q[T2_POL3] && $fell(ceBusy) |=> coreFlag_q[3])
		else $error("busy fall did not flag line 3");
	AST_LOCK_BOTH: assert property (@(posedge clk) disable iff (!rstn)
		enLock_q[XL_LOCK] && !any4 && $changed(pllLock) && !sfrWrEn && !xWrEn
		|-> ##2 coreFlag_q[4])
		else $error("lock change did not flag line 4");
	AST_EXT6_MANUAL: assert property (@(posedge clk) disable iff (!rstn)
		ackValid && ackSrc == SRC_EXT6 && coreFlag_q[6] && !sfrWrEn |=> coreFlag_q[6])
		else $error("line 6 flag cleared by vectoring");
	AST_AUTO_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
		ackValid && ackSrc == SRC_EXT5 && !lineRise[3] && !sfrWrEn |=> !coreFlag_q[5])
		else $error("line 5 flag not cleared by vectoring");
	AST_ONES_KEEP: assert property (@(posedge clk) disable iff (!rstn)
		sfrWrEn && sfrAddr == SFR_SUB_FLAGS
		|=> &(subFlag_q | ~($past(subFlag_q) & $past(sfrWrData))))
		else $error("sub flag cleared by a one write");
	AST_WAKE_SET: assert property (@(posedge clk) disable iff (!rstn)
		$rose(timerWakeup) |=> subFlag_q[SF_TWAKE])
		else $error("timer wake flag not set");
	AST_BUTTON_SET: assert property (@(posedge clk) disable iff (!rstn)
		$rose(pushButton) |=> subFlag_q[SF_BUTTON])
		else $error("button flag not set");
	AST_GLOBAL_OFF: assert property (@(posedge clk) disable iff (!rstn)
		!ien0_q[IEN0_GLOB] |=> !irq_q.valid)
		else $error("request raised while globally disabled");
	AST_PREEMPT: assert property (@(posedge clk) disable iff (!rstn)
		irq_q.valid |-> !$past(haveActive) || irq_q.level > $past(curLevel))
		else $error("request not above level in service");
	AST_GATE: assert property (@(posedge clk) disable iff (!rstn)
		!enLock_q[XL_COL] && !enMisc_q[XM_SPI] && !timer2_control_reg_q[T2_POL2] && !sfrWrEn
		|=> !$rose(coreFlag_q[2]))
		else $error("disabled sub source reached line 2");

endmodule // mepic_ctrl

// ==== dv/mepic_core_model.sv ====
`timescale 1ns/1ps
module mepic_core_model
	import mepic_pkg::*;
#(
	parameter int SVC = 12
)(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  mepic_req_t      irqReq,
	output logic            ackValid,
	output logic [3:0]      ackSrc,
	output logic            retiPulse
);
	int gap;
	int cnt;
	int depth;

	// vectors on any offered request; nesting is left to the controller to police
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ackValid  <= 1'b0;
			ackSrc    <= 4'h0;
			retiPulse <= 1'b0;
			gap       <= 0;
			cnt       <= 0;
			depth     <= 0;
		end
		else
		begin
			ackValid  <= 1'b0;
			retiPulse <= 1'b0;
			if (gap > 0)
				gap <= gap - 1;
			if (depth > 0 && cnt > 0)
				cnt <= cnt - 1;
			// gap covers the registered request lagging the flag clear
			if (depth > 0 && cnt == 1)
			begin
				retiPulse <= 1'b1;
				depth     <= depth - 1;
				cnt       <= SVC;
				gap       <= 3;
			end
			else if (enable && irqReq.valid && gap == 0)
			begin
				ackValid <= 1'b1;
				ackSrc   <= irqReq.src;
				depth    <= depth + 1;
				cnt      <= SVC;
				gap      <= 3;
			end
		end
	end
endmodule // mepic_core_model

// ==== dv/mepic_ctrl_tb.sv ====
`timescale 1ns/1ps
module mepic_ctrl_tb;
	import mepic_pkg::*;
	logic        clk;
	logic        rstn;
	logic [7:0]  sfrAddr;
	logic        sfrWrEn;
	logic [7:0]  sfrWrData;
	logic [7:0]  sfrRdData;
	logic [15:0] xAddr;
	logic        xWrEn;
	logic [7:0]  xWrData;
	logic [7:0]  xRdData;
	logic [16:0] ev;
	logic        modelEn;
	logic        ackValid;
	logic [3:0]  ackSrc;
	logic        retiPulse;
	mepic_req_t  irqReq;
	int          n_errors;
	int          checks;
	logic [3:0]  ackLog [$];
	logic [15:0] regA [15] = '{16'h0088, 16'h009a, 16'h00a8, 16'h00a9, 16'h00b8, 16'h00b9,
		16'h00c0, 16'h00c8, 16'h00e8, 16'h0055, 16'h2002, 16'h2007, 16'h20b0, 16'h20b1, 16'h3000};
	logic [7:0]  regM [15] = '{MASK_TCON, MASK_IEN2, MASK_IEN0, MASK_PRIO, MASK_IEN1, MASK_PRIO,
		MASK_IRCON, MASK_TIMER2_CONTROL_REG, 8'h00, 8'h00, MASK_XWAKE, MASK_XLOCK, MASK_XMISC, 8'h00, 8'h00};
	int          subIdx [10] = '{8, 9, 3, 2, 12, 11, 6, 6, 10, 4};
	int          lnIdx [12] = '{4, 6, 6, 7, 8, 5, 5, 0, 1, 10, 9, 2};
	int          lnBit [12] = '{1, 3, 3, 4, 5, 2, 2, 1, 3, 5, 5, 1};

	mepic_ctrl i_dut (.clk(clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .xAddr(xAddr), .xWrEn(xWrEn),
		.xWrData(xWrData), .xRdData(xRdData), .dioHighEvent(ev[0]), .dioLowEvent(ev[1]),
		.flashCollisionA(ev[2]), .flashCollisionB(ev[3]), .spiEvent(ev[4]), .ceBusy(ev[5]),
		.pllLock(ev[6]), .eepromBusy(ev[7]), .transferBusy(ev[8]), .oneSecondTick(ev[9]),
		.watchdogNearOverflow(ev[10]), .timerWakeup(ev[11]), .pushButton(ev[12]),
		.timer0Req(ev[13]), .timer1Req(ev[14]), .serial0Req(ev[15]), .serial1Req(ev[16]),
		.ackValid(ackValid), .ackSrc(ackSrc), .retiPulse(retiPulse), .irqReq(irqReq));

	mepic_core_model i_model (.clk(clk), .rstn(rstn), .enable(modelEn), .irqReq(irqReq),
		.ackValid(ackValid), .ackSrc(ackSrc), .retiPulse(retiPulse));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one task for both spaces: the upper address byte picks the memory-mapped port
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr   <= a[7:0];
		xAddr     <= a;
		sfrWrData <= d;
		xWrData   <= d;
		sfrWrEn   <= ~|a[15:8];
		xWrEn     <= |a[15:8];
		@(posedge clk);
		sfrWrEn   <= 1'b0;
		xWrEn     <= 1'b0;
	endtask

	task automatic chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		sfrAddr <= a[7:0];
		xAddr   <= a;
		@(posedge clk);
		#1;
		check({8'h00, (|a[15:8]) ? xRdData : sfrRdData}, {8'h00, e});
	endtask

	task automatic toggle(input logic [16:0] m);
		@(posedge clk);
		ev <= ev ^ m;
	endtask

	task automatic waitLog(input int n);
		for (int i = 0; i < 400 && ackLog.size() < n; i++)
			@(posedge clk);
	endtask

	// leaves the bench just after the edge at which a request first stands
	task automatic waitReq;
		for (int i = 0; i < 50 && !irqReq.valid; i++)
		begin
			@(posedge clk);
			#1;
		end
	endtask

	// nibble f in the log marks a handler return
	task automatic logChk(input logic [31:0] exp, input int n);
		waitLog(n);
		tick(3);
		check(16'(ackLog.size()), 16'(n));
		for (int i = 0; i < n; i++)
			check({12'h000, ackLog[i]}, {12'h000, exp[31-4*i -: 4]});
		ackLog.delete();
	endtask

	task automatic close_out;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		if (ackValid)
			ackLog.push_back(ackSrc);
		if (retiPulse)
			ackLog.push_back(4'hf);
	end

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		#200us;
		n_errors++;
		close_out();
	end

	initial
	begin
		rstn = 1'b0;
		sfrAddr = 8'h00;
		sfrWrEn = 1'b0;
		sfrWrData = 8'h00;
		xAddr = 16'h0000;
		xWrEn = 1'b0;
		xWrData = 8'h00;
		modelEn = 1'b0;
		ev = 17'h007a0; // falling-edge sources idle high
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 15; i++)
		begin
			chk(regA[i], 8'h00);
			wr(regA[i], 8'hff);
			chk(regA[i], regM[i]);
			wr(regA[i], 8'h00);
		end
		$display("test registers done");
		// sub enables left at zero: flags set but nothing reaches the core
		wr(16'h00a8, 8'h80);
		wr(16'h00b8, 8'h3e);
		for (int i = 0; i < 10; i++)
		begin
			toggle(17'(1) << subIdx[i]);
			tick(3);
			chk(i < 8 ? 16'h00e8 : 16'h20b1, 8'h01 << (i < 8 ? i : (i == 8 ? 0 : 4)));
			check({15'h0000, irqReq.valid}, 16'h0000);
			wr(i < 8 ? 16'h00e8 : 16'h20b1, 8'hff);
			chk(i < 8 ? 16'h00e8 : 16'h20b1, 8'h01 << (i < 8 ? i : (i == 8 ? 0 : 4)));
			wr(i < 8 ? 16'h00e8 : 16'h20b1, ~(8'h01 << (i < 8 ? i : (i == 8 ? 0 : 4))));
			chk(i < 8 ? 16'h00e8 : 16'h20b1, 8'h00);
			if (subIdx[i] != 6)
				toggle(17'(1) << subIdx[i]);
			tick(2);
		end
		$display("test sub-source flags done");
		wr(16'h00a8, 8'h00);
		wr(16'h2002, 8'h03);
		wr(16'h2007, 8'h30);
		wr(16'h20b0, 8'h11);
		for (int i = 0; i < 12; i++)
		begin
			wr(16'h00c8, i == 6 ? 8'h40 : 8'h00);
			toggle(17'(1) << lnIdx[i]);
			tick(4);
			chk(lnIdx[i] < 2 ? 16'h0088 : 16'h00c0, 8'h01 << lnBit[i]);
			check({15'h0000, irqReq.valid}, 16'h0000);
			if (lnIdx[i] != 6 && lnIdx[i] != 5)
				toggle(17'(1) << lnIdx[i]);
			tick(2);
			wr(16'h00c0, 8'h00);
			wr(16'h0088, 8'h00);
			wr(16'h00e8, 8'h00);
			wr(16'h20b1, 8'h00);
		end
		wr(16'h00c8, 8'h00);
		$display("test line mapping done");
		modelEn <= 1'b1;
		wr(16'h00a8, 8'h85);
		toggle(17'h000a3);
		logChk(32'h0f4f5f9f, 8);
		chk(16'h00c0, 8'h00);
		chk(16'h0088, 8'h00);
		toggle(17'h000a3);
		// levels are set with the global enable off
		wr(16'h00a8, 8'h05);
		wr(16'h00a9, 8'h14);
		wr(16'h00b9, 8'h10);
		wr(16'h00a8, 8'h85);
		toggle(17'h000a3);
		waitReq();
		check({14'h0000, irqReq.level}, 16'h0003);
		check({12'h000, irqReq.src}, {12'h000, SRC_EXT5});
		logChk(32'h9f4f5f0f, 8);
		toggle(17'h000a3);
		toggle(17'h00001);
		waitLog(1);
		toggle(17'h00020);
		waitLog(2);
		tick(2);
		toggle(17'h00002);
		logChk(32'h05f4ff00, 6);
		// timer 0 shares group 1; lifted above external 0 it must win
		toggle(17'h00023);
		wr(16'h00a8, 8'h07);
		wr(16'h00a9, 8'h16);
		wr(16'h00a8, 8'h87);
		toggle(17'h02001);
		waitLog(1);
		toggle(17'h02000);
		logChk(32'h2f0f0000, 4);
		$display("test priority done");
		toggle(17'h00100);
		waitLog(1);
		chk(16'h00c0, 8'h20);
		wr(16'h00c0, 8'h00);
		wr(16'h00e8, 8'h00);
		logChk(32'haf000000, 2);
		$display("test manual clear done");
		close_out();
	end
endmodule // mepic_ctrl_tb
